/* rtl/rtxs_pkg.sv */
// Purpose: Shared constants and types for the transmitter enable sequencer
// Assumes: 100 MHz reference clock
// Notes:   Lock time is a chosen figure below the 1 ms ceiling
package rtxs_pkg;

  localparam int          CLK_PERIOD_NS   = 10;
  // Oscillator plus PLL settling; must stay under 1 ms
  localparam int          LOCK_TIME_NS    = 900_000;
  // Longest time, so rounded down
  localparam int          LOCK_CYCLES_DEF = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int          LOCK_CNT_W      = 20;
  localparam int          DIV_W           = 2;
  localparam logic [5:0]  CARRIER_MULT    = 6'h20;

  typedef enum logic [1:0] {
    RTXS_STANDBY,
    RTXS_OSC_PLL,
    RTXS_TRANSMIT
  } rtxs_mode_type;

  typedef struct packed {
    logic chip_en;
    logic amp_key;
    logic fsk_closed;
  } rtxs_pin_type;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic clkdrv_en;
    logic amp_en;
    logic freq_low;
  } rtxs_rf_type;

endpackage

/* rtl/rtxs_sequencer.sv */
// Purpose: Power-mode, lock timing and modulation control of the transmitter
// Assumes: Pins come from the controller, asynchronous to clk_in
// Notes:   Amplifier follows its keying pin three clk_in cycles late, while chip enable is high
//
// Function
// RULE1: Both enables low gives full standby
// RULE2: Chip enable only runs oscillator, PLL, clock
// RULE3: Both enables high turns everything on
// RULE4: Amplifier directly follows its keying input; here only while chip enable is high, three clk_in cycles late
// RULE5: Lock and stable clock within 1 ms
// RULE6: Controller waits 1 ms before using clock
// RULE7: Controller ends: amplifier, clock source, enable
// RULE8: Controller keys FSK via open-drain capacitor
// RULE9: Closed switch lower, open switch higher frequency
// RULE10: Carrier locks to 32 times crystal
// RULE11: Controller starts on RC, switches after 1 ms
// RULE12: Clock output is crystal frequency over four
// RULE13: Controller switches clocks glitch-free, never early
`timescale 1ns/1ps
module rtxs_sequencer
  import rtxs_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYCLES_DEF
) (
  input  wire logic          clk_in,
  input  wire logic          sys_rst_in,
  input  wire logic          link_clk_in,
  input  wire logic          chip_enable_in,
  input  wire logic          amp_keying_input_in,
  input  wire logic          fsk_cap_closed_in,
  output rtxs_rf_type        rf_ctrl_out,
  output rtxs_mode_type      mode_out,
  output logic               pll_locked_out,
  output logic               ctrl_clk_out,
  output logic [5:0]         carrier_mult_out,
  output logic               clk_ready_link_out
);

  localparam logic [LOCK_CNT_W-1:0] LOCK_MAX = LOCK_CNT_W'(LOCK_CYCLES);

  // Longer counts would break the 1 ms lock promise
  if (LOCK_CYCLES < 1 || LOCK_CYCLES > LOCK_CYCLES_DEF
      || LOCK_CYCLES >= (1 << LOCK_CNT_W)) begin : g_lock_range
    $error("LOCK_CYCLES out of range");
  end

  // Pin synchronisers
  rtxs_pin_type pin_meta;
  rtxs_pin_type pin_s;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else begin
      pin_meta <= '{chip_en: chip_enable_in,
                    amp_key: amp_keying_input_in,
                    fsk_closed: fsk_cap_closed_in};
      pin_s    <= pin_meta;
    end
  end

  // Mode and analog enables
  rtxs_mode_type          mode;
  rtxs_mode_type          next_mode;
  rtxs_rf_type            rf_ctrl;
  rtxs_rf_type            next_rf_ctrl;
  logic [5:0]             carrier_mult;
  logic [5:0]             next_carrier_mult;

  always_comb begin
    case ({pin_s.chip_en, pin_s.amp_key})
      2'b10:   next_mode = RTXS_OSC_PLL;
      2'b11:   next_mode = RTXS_TRANSMIT; // RULE4
      // Amplifier without oscillator makes no carrier, so held off
      default: next_mode = RTXS_STANDBY; // RULE1
    endcase
    next_rf_ctrl = '0;
    case (next_mode)
      RTXS_OSC_PLL: begin
        next_rf_ctrl.osc_en    = 1'b1; // RULE2
        next_rf_ctrl.pll_en    = 1'b1;
        next_rf_ctrl.clkdrv_en = 1'b1;
      end
      RTXS_TRANSMIT: begin
        next_rf_ctrl.osc_en    = 1'b1; // RULE3
        next_rf_ctrl.pll_en    = 1'b1;
        next_rf_ctrl.clkdrv_en = 1'b1;
        next_rf_ctrl.amp_en    = 1'b1;
      end
      default: next_rf_ctrl = '0;
    endcase
    // Pulled reference drops the carrier while the switch is closed
    next_rf_ctrl.freq_low = pin_s.chip_en && pin_s.fsk_closed; // RULE9
    next_carrier_mult = next_rf_ctrl.pll_en ? CARRIER_MULT : 6'h00; // RULE10
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode         <= RTXS_STANDBY;
      rf_ctrl      <= '0;
      carrier_mult <= 6'h00;
    end else begin
      mode         <= next_mode;
      rf_ctrl      <= next_rf_ctrl;
      carrier_mult <= next_carrier_mult;
    end
  end

  // Lock timer and divided clock output
  logic [LOCK_CNT_W-1:0]  lock_cnt;
  logic [LOCK_CNT_W-1:0]  next_lock_cnt;
  logic                   locked;
  logic                   next_locked;
  logic [DIV_W-1:0]       div;
  logic [DIV_W-1:0]       next_div;
  logic                   ctrl_clk;
  logic                   next_ctrl_clk;

  always_comb begin
    if (next_mode == RTXS_STANDBY) begin
      next_lock_cnt = '0;
    end else if (lock_cnt == LOCK_MAX) begin
      next_lock_cnt = lock_cnt;
    end else begin
      next_lock_cnt = lock_cnt + 1'b1; // RULE5
    end
    next_locked = (next_mode != RTXS_STANDBY) && (next_lock_cnt == LOCK_MAX);
    // Clock held low until lock so the controller never sees a runt
    next_div      = locked ? div + 1'b1 : '0; // RULE12
    next_ctrl_clk = next_locked && next_div[DIV_W-1]; // RULE5
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      lock_cnt <= '0;
      locked   <= 1'b0;
      div      <= '0;
      ctrl_clk <= 1'b0;
    end else begin
      lock_cnt <= next_lock_cnt;
      locked   <= next_locked;
      div      <= next_div;
      ctrl_clk <= next_ctrl_clk;
    end
  end

  // Check-only oscillator age, kept apart from lock_cnt
  // so the lock checks do not lean on the counter they guard
  logic [LOCK_CNT_W-1:0]  osc_age;
  logic [LOCK_CNT_W-1:0]  next_osc_age;

  always_comb begin
    if (!rf_ctrl.osc_en) begin
      next_osc_age = '0;
    end else if (osc_age == LOCK_MAX) begin
      next_osc_age = osc_age;
    end else begin
      next_osc_age = osc_age + 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      osc_age <= '0;
    end else begin
      osc_age <= next_osc_age;
    end
  end

  // Lock status toward the controller's clock domain
  logic                   link_rst_meta;
  logic                   link_rst;
  logic                   lock_meta;
  logic                   lock_link;

  always_ff @(posedge link_clk_in) begin
    link_rst_meta <= sys_rst_in;
    link_rst      <= link_rst_meta;
  end

  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      lock_meta <= 1'b0;
      lock_link <= 1'b0;
    end else begin
      lock_meta <= locked;
      lock_link <= lock_meta;
    end
  end

  assign rf_ctrl_out        = rf_ctrl;
  assign mode_out           = mode;
  assign pll_locked_out     = locked;
  assign ctrl_clk_out       = ctrl_clk;
  assign carrier_mult_out   = carrier_mult;
  assign clk_ready_link_out = lock_link;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence standby_req_s;
    !pin_s.chip_en && !pin_s.amp_key;
  endsequence

  sequence idle_req_s;
    pin_s.chip_en && !pin_s.amp_key;
  endsequence

  sequence tx_req_s;
    pin_s.chip_en && pin_s.amp_key;
  endsequence

  sequence key_edge_s;
    pin_s.chip_en && $changed(pin_s.amp_key);
  endsequence

  standby_off_a: assert property ( // RULE1
    standby_req_s |=> (rf_ctrl_out == '0) && !pll_locked_out
      && !ctrl_clk_out)
    else $error("standby left something on");

  idle_pll_a: assert property ( // RULE2
    idle_req_s |=> rf_ctrl_out.osc_en && rf_ctrl_out.pll_en
      && rf_ctrl_out.clkdrv_en && !rf_ctrl_out.amp_en)
    else $error("idle mode enables wrong");

  transmit_on_a: assert property ( // RULE3
    tx_req_s |=> rf_ctrl_out.osc_en && rf_ctrl_out.pll_en
      && rf_ctrl_out.clkdrv_en && rf_ctrl_out.amp_en)
    else $error("transmit mode enables wrong");

  ask_keying_a: assert property ( // RULE4
    key_edge_s |=> rf_ctrl_out.amp_en == $past(pin_s.amp_key))
    else $error("amplifier did not follow keying");

  lock_wait_a: assert property ( // RULE5
    (rf_ctrl_out.osc_en && osc_age >= LOCK_MAX - 1'b1) |-> pll_locked_out)
    else $error("lock not reached in time");

  lock_exact_a: assert property ( // RULE5
    $rose(pll_locked_out) |-> osc_age == LOCK_MAX - 1'b1
      && rf_ctrl_out.pll_en)
    else $error("lock flagged at wrong count");

  fsk_freq_a: assert property ( // RULE9
    pin_s.chip_en |=> rf_ctrl_out.freq_low == $past(pin_s.fsk_closed))
    else $error("fsk frequency select wrong");

  carrier_mult_a: assert property ( // RULE10
    rf_ctrl_out.pll_en |-> carrier_mult_out == CARRIER_MULT)
    else $error("carrier multiple wrong");

  clk_quarter_a: assert property ( // RULE12
    (pll_locked_out && $past(pll_locked_out, 4)) |->
      ctrl_clk_out == $past(ctrl_clk_out, 4)
      && ctrl_clk_out != $past(ctrl_clk_out, 2))
    else $error("clock output not divide by four");

  clk_quiet_a: assert property ( // RULE5
    !pll_locked_out |-> !ctrl_clk_out)
    else $error("clock output before lock");

  sequence orphan_key_s;
    !pin_s.chip_en && pin_s.amp_key;
  endsequence

  orphan_key_a: assert property ( // RULE1
    orphan_key_s |=> !rf_ctrl_out.amp_en && mode_out == RTXS_STANDBY)
    else $error("amplifier on without chip enable");

  standby_mode_a: assert property ( // RULE1
    standby_req_s |=> mode_out == RTXS_STANDBY && carrier_mult_out == 6'h00)
    else $error("standby mode not reached");

  clk_driver_a: assert property ( // RULE2
    ctrl_clk_out |-> rf_ctrl_out.clkdrv_en)
    else $error("clock output with driver off");

  mode_amp_a: assert property ( // RULE3
    rf_ctrl_out.amp_en |-> mode_out == RTXS_TRANSMIT)
    else $error("amplifier on outside transmit mode");

  key_follow_a: assert property ( // RULE4
    tx_req_s ##1 idle_req_s |=> !rf_ctrl_out.amp_en
      && rf_ctrl_out.osc_en)
    else $error("amplifier not released on key low");

  lock_hold_a: assert property ( // RULE5
    (pll_locked_out && rf_ctrl_out.osc_en) |=>
      pll_locked_out || !rf_ctrl_out.osc_en)
    else $error("lock dropped while oscillator ran");

  fsk_gate_a: assert property ( // RULE9
    !pin_s.chip_en |=> !rf_ctrl_out.freq_low)
    else $error("frequency pulled in standby");

  pll_needs_osc_a: assert property ( // RULE10
    rf_ctrl_out.pll_en |-> rf_ctrl_out.osc_en)
    else $error("synthesiser on without oscillator");

  mult_off_a: assert property ( // RULE10
    !rf_ctrl_out.pll_en |-> carrier_mult_out == 6'h00)
    else $error("carrier multiple set with synthesiser off");

endmodule // rtxs_sequencer

/* dv/rtxs_host.sv */
// Purpose: Behavioural controller driving the transmitter enable pins
// Assumes: Pins change just after a falling clock edge
// Notes:   Clock take-over is only a flag; no real clock mux here
`timescale 1ns/1ps
module rtxs_host (
  input  wire logic clk_in,
  input  wire logic ready_in,
  output logic      chip_enable_out,
  output logic      amp_key_out,
  output logic      fsk_closed_out,
  output logic      use_tx_clk_out
);
  initial begin
    chip_enable_out = 1'b0;
    amp_key_out     = 1'b0;
    fsk_closed_out  = 1'b0;
    use_tx_clk_out  = 1'b0;
  end
  task automatic enable();
    @(negedge clk_in);
    chip_enable_out = 1'b1;
  endtask
  task automatic take_clock(input int wait_cyc);
    // Amplifier stays low through the whole wait
    repeat (wait_cyc) @(negedge clk_in);
    use_tx_clk_out = chip_enable_out & ready_in;
  endtask
  task automatic key(input logic amp, input logic sw);
    @(negedge clk_in);
    amp_key_out    = amp;
    fsk_closed_out = sw;
  endtask
  task automatic shut_down();
    @(negedge clk_in);
    amp_key_out    = 1'b0;
    fsk_closed_out = 1'b0;
    @(negedge clk_in);
    use_tx_clk_out = 1'b0;
    @(negedge clk_in);
    chip_enable_out = 1'b0;
  endtask
endmodule // rtxs_host

/* dv/test_rf_tx_enable_sequencer.sv */
// Purpose: Self-checking bench for the enable sequencer
// Assumes: Lock count shortened to 20 cycles
// Notes:   Outputs sampled at falling edges, settled
`timescale 1ns/1ps
module test_rf_tx_enable_sequencer;
  import rtxs_pkg::*;
  localparam int LOCK = 20;
  logic clk_in = 1'b0, link_clk = 1'b0, sys_rst_in = 1'b1;
  logic chip, amp, fsk, use_clk, locked, cclk, ready;
  rtxs_rf_type   rf;
  rtxs_mode_type mode;
  logic [5:0]    mult;
  int bad_count = 0, comparisons = 0, n;
  initial forever #5 clk_in = ~clk_in;
  initial begin #3; forever #24 link_clk = ~link_clk; end
  rtxs_sequencer #(.LOCK_CYCLES(LOCK)) rtxs_sequencer_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .link_clk_in(link_clk),
    .chip_enable_in(chip), .amp_keying_input_in(amp),
    .fsk_cap_closed_in(fsk), .rf_ctrl_out(rf), .mode_out(mode),
    .pll_locked_out(locked), .ctrl_clk_out(cclk),
    .carrier_mult_out(mult), .clk_ready_link_out(ready));
  rtxs_host rtxs_host_i (.clk_in(clk_in), .ready_in(ready),
    .chip_enable_out(chip), .amp_key_out(amp),
    .fsk_closed_out(fsk), .use_tx_clk_out(use_clk));
  task automatic chk(input string name, input logic [7:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic settle(input logic [4:0] exp_rf, input logic [1:0] exp_m);
    repeat (3) @(negedge clk_in);
    chk("rf_ctrl", {3'h0, rf}, {3'h0, exp_rf});
    chk("mode", {6'h00, mode}, {6'h00, exp_m});
  endtask
  task automatic t_standby();
    chk("rf_idle", {3'h0, rf}, 8'h00);
    rtxs_host_i.key(1'b1, 1'b1);
    settle(5'h00, RTXS_STANDBY);
    chk("mult_idle", {2'h0, mult}, 8'h00);
    rtxs_host_i.key(1'b0, 1'b0);
    $display("standby test done");
  endtask
  task automatic t_power_up();
    logic prev_clk;
    int   highs;
    rtxs_host_i.enable();
    settle(5'h1C, RTXS_OSC_PLL);
    chk("mult", {2'h0, mult}, 8'h20);
    chk("early_clk", {7'h00, cclk}, 8'h00);
    n = 3;
    while (locked !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    chk("lock_seen", {7'h00, locked}, 8'h01);
    if (locked !== 1'b1) return;
    chk("lock_time", {7'h00, n >= LOCK && n <= LOCK + 4}, 8'h01);
    n = 0;
    highs = 0;
    prev_clk = cclk;
    repeat (8) begin
      @(negedge clk_in);
      if (cclk === 1'b1 && prev_clk === 1'b0) n++;
      if (cclk === 1'b1) highs++;
      prev_clk = cclk;
    end
    chk("clk_rises", n[7:0], 8'h02);
    chk("clk_highs", highs[7:0], 8'h04);
    rtxs_host_i.take_clock(20);
    chk("ready", {7'h00, use_clk}, 8'h01);
    chk("ready_link", {7'h00, ready}, 8'h01);
    $display("power-up test done");
  endtask
  task automatic t_ask();
    rtxs_host_i.key(1'b1, 1'b0);
    settle(5'h1E, RTXS_TRANSMIT);
    rtxs_host_i.key(1'b0, 1'b0);
    settle(5'h1C, RTXS_OSC_PLL);
    $display("keying test done");
  endtask
  task automatic t_fsk();
    rtxs_host_i.key(1'b1, 1'b1);
    settle(5'h1F, RTXS_TRANSMIT);
    rtxs_host_i.key(1'b1, 1'b0);
    settle(5'h1E, RTXS_TRANSMIT);
    $display("frequency test done");
  endtask
  task automatic t_shut_down();
    rtxs_host_i.shut_down();
    settle(5'h00, RTXS_STANDBY);
    chk("unlock", {7'h00, locked}, 8'h00);
    chk("mult_off", {2'h0, mult}, 8'h00);
    repeat (16) @(negedge clk_in);
    chk("ready_off", {7'h00, ready}, 8'h00);
    $display("shutdown test done");
  endtask
  task automatic t_mid_reset();
    rtxs_host_i.enable();
    settle(5'h1C, RTXS_OSC_PLL);
    repeat (LOCK + 4) @(negedge clk_in);
    chk("relock", {7'h00, locked}, 8'h01);
    sys_rst_in = 1'b1;
    repeat (16) @(negedge clk_in);
    chk("rst_rf", {3'h0, rf}, 8'h00);
    chk("rst_mode", {6'h00, mode}, {6'h00, RTXS_STANDBY});
    chk("rst_lock", {7'h00, locked}, 8'h00);
    chk("rst_ready", {7'h00, ready}, 8'h00);
    sys_rst_in = 1'b0;
    settle(5'h1C, RTXS_OSC_PLL);
    chk("rst_clk", {7'h00, cclk}, 8'h00);
    chk("rst_unlock", {7'h00, locked}, 8'h00);
    rtxs_host_i.shut_down();
    settle(5'h00, RTXS_STANDBY);
    $display("mid-run reset test done");
  endtask
  initial begin
    repeat (10) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (2) @(negedge clk_in);
    t_standby();
    t_power_up();
    t_ask();
    t_fsk();
    t_shut_down();
    t_mid_reset();
    report_and_stop();
  end
endmodule // test_rf_tx_enable_sequencer
